// [rtl/mdfp_pkg.sv]
package mdfp_pkg;
   // Bus map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_TSCALE = 8'h08;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Control bits
   localparam int CTRL_DIR_BIT = 0;
   localparam int CTRL_LOCKEN_BIT = 1;
   localparam logic [31:0] CTRL_RESET = 32'h00000003;
   localparam logic [7:0] TSCALE_RESET = 8'h01;
   // Timing
   localparam int CLK_MHZ = 100;
   localparam int SOFT_BLANK_NS = 1900;
   localparam int HARD_BLANK_NS = 1300;
   localparam int HARD_HOLD_MS = 15;
   localparam int LOCK_DETECT_S = 6;
   localparam int LOCK_HOLD_S = 35;
   localparam int TICK_US = 1;
   localparam int TICK_CYC = TICK_US * CLK_MHZ;
   localparam int SOFT_BLANK_CYC = (SOFT_BLANK_NS * CLK_MHZ + 999) / 1000;
   localparam int HARD_BLANK_CYC = (HARD_BLANK_NS * CLK_MHZ + 999) / 1000;
   localparam int HARD_HOLD_TICKS = HARD_HOLD_MS * 1000 / TICK_US;
   localparam int LOCK_DETECT_TICKS = LOCK_DETECT_S * 1000000 / TICK_US;
   localparam int LOCK_HOLD_TICKS = LOCK_HOLD_S * 1000000 / TICK_US;
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_TRIP = 2'b01,
      ST_LOCK = 2'b10
   } mdfp_state_e;
   typedef struct packed {
      logic uHigh;
      logic uLow;
      logic vHigh;
      logic vLow;
      logic wHigh;
      logic wLow;
   } mdfp_gate_s;
endpackage

// [rtl/mdfp_top.sv]
`timescale 1ns/1ps
`default_nettype none
module mdfp_top #(
   parameter int HOLD_TICKS = mdfp_pkg::HARD_HOLD_TICKS,
   parameter int DETECT_TICKS = mdfp_pkg::LOCK_DETECT_TICKS,
   parameter int LOCK_TICKS = mdfp_pkg::LOCK_HOLD_TICKS,
   parameter int TICK_CYCLES = mdfp_pkg::TICK_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Pins
   input wire logic hallU,
   input wire logic hallV,
   input wire logic hallW,
   input wire logic softLimitCmp,
   input wire logic hardTripCmp,
   input wire logic thermHighCmp,
   input wire logic thermLowCmp,
   input wire logic pwmPeriodStart,
   input wire logic [5:0] sineGates,
   output logic [5:0] gateOut,
   output logic faultOut,
   // AXI4-Lite
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   // Every pin input passes two flops before use
   logic [8:0] syncA_q, syncB_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         syncA_q <= 9'h000;
         syncB_q <= 9'h000;
      end else begin
         syncA_q <= {pwmPeriodStart, thermLowCmp, thermHighCmp, hardTripCmp,
                     softLimitCmp, hallU, hallV, hallW, 1'b0};
         syncB_q <= syncA_q;
      end
   end
   logic [2:0] hall;
   logic softS, hardS, thHiS, thLoS, pwmS;
   assign hall = syncB_q[3:1];
   assign softS = syncB_q[4];
   assign hardS = syncB_q[5];
   assign thHiS = syncB_q[6];
   assign thLoS = syncB_q[7];
   assign pwmS = syncB_q[8];
   logic [5:0] sineS_q, sineSS_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sineS_q <= 6'h00;
         sineSS_q <= 6'h00;
      end else begin
         sineS_q <= sineGates;
         sineSS_q <= sineS_q;
      end
   end

   // Registers
   logic [31:0] ctrl_q;
   logic [7:0] tscale_q;
   logic awHave_q, wHave_q;
   logic [7:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   assign awready = !awHave_q && !bvalid;
   assign wready = !wHave_q && !bvalid;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         awHave_q <= 1'b0;
         wHave_q <= 1'b0;
         awAddr_q <= 8'h00;
         wData_q <= 32'h00000000;
         wStrb_q <= 4'h0;
         bvalid <= 1'b0;
         bresp <= mdfp_pkg::RESP_OKAY;
         ctrl_q <= mdfp_pkg::CTRL_RESET;
         tscale_q <= mdfp_pkg::TSCALE_RESET;
      end else begin
         if (awvalid && awready) begin
            awHave_q <= 1'b1;
            awAddr_q <= awaddr;
         end
         if (wvalid && wready) begin
            wHave_q <= 1'b1;
            wData_q <= wdata;
            wStrb_q <= wstrb;
         end
         if (awHave_q && wHave_q && !bvalid) begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            bvalid <= 1'b1;
            bresp <= mdfp_pkg::RESP_OKAY;
            if (awAddr_q == mdfp_pkg::REG_CTRL) begin
               if (wStrb_q[0]) ctrl_q[7:0] <= wData_q[7:0];
            end else if (awAddr_q == mdfp_pkg::REG_TSCALE) begin
               if (wStrb_q[0] && wData_q[7:0] != 8'h00) tscale_q <= wData_q[7:0];
            end else if (awAddr_q != mdfp_pkg::REG_STATUS) begin
               bresp <= mdfp_pkg::RESP_SLVERR;
            end
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end
   logic dirFwd, lockEn;
   assign dirFwd = ctrl_q[mdfp_pkg::CTRL_DIR_BIT];
   assign lockEn = ctrl_q[mdfp_pkg::CTRL_LOCKEN_BIT];

   // Protection state
   mdfp_pkg::mdfp_state_e state_q;
   logic softCut_q, thermal_q, reverse_q, illegal_q;
   logic [31:0] tickCnt_q, holdCnt_q, lockCnt_q;
   logic [15:0] softBlank_q, hardBlank_q;
   logic tick;
   logic [2:0] hallPrev_q;
   assign tick = (tickCnt_q == 32'h0);

   // Timebase stretched by the resistor scale
   always_ff @(posedge clk or posedge rst) begin
      if (rst) tickCnt_q <= 32'h0;
      else if (tick) tickCnt_q <= 32'(TICK_CYCLES * tscale_q - 1);
      else tickCnt_q <= tickCnt_q - 32'h1;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         softBlank_q <= 16'h0000;
         softCut_q <= 1'b0;
      end else begin
         // 16-bit count so the largest scale still fits the blanking span
         softBlank_q <= softS ? softBlank_q + 16'(softBlank_q != 16'hffff) : 16'h0000;
         if (softS && softBlank_q >= 16'(mdfp_pkg::SOFT_BLANK_CYC) * {8'h00, tscale_q} - 16'h1)
            softCut_q <= 1'b1;
         else if (pwmS)
            softCut_q <= 1'b0;
      end
   end

   logic hardHit, hallOk;
   assign hardHit = hardS
      && hardBlank_q >= 16'(mdfp_pkg::HARD_BLANK_CYC) * {8'h00, tscale_q} - 16'h1;
   assign hallOk = hall != 3'b000 && hall != 3'b111;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hardBlank_q <= 16'h0000;
         state_q <= mdfp_pkg::ST_RUN;
         holdCnt_q <= 32'h0;
         lockCnt_q <= 32'h0;
         hallPrev_q <= 3'b000;
      end else begin
         hardBlank_q <= hardS ? hardBlank_q + 16'(hardBlank_q != 16'hffff) : 16'h0000;
         hallPrev_q <= hall;
         case (state_q)
            mdfp_pkg::ST_RUN: begin
               // Held at zero while disabled, so enabling cannot trip at once
               if (hall != hallPrev_q || !lockEn) lockCnt_q <= 32'h0;
               else if (tick) lockCnt_q <= lockCnt_q + 32'h1;
               if (hardHit) begin
                  state_q <= mdfp_pkg::ST_TRIP;
                  holdCnt_q <= 32'h0;
               end else if (lockEn && lockCnt_q >= DETECT_TICKS) begin
                  state_q <= mdfp_pkg::ST_LOCK;
                  holdCnt_q <= 32'h0;
               end
            end
            mdfp_pkg::ST_TRIP: begin
               if (tick) holdCnt_q <= holdCnt_q + 32'h1;
               if (holdCnt_q >= HOLD_TICKS) state_q <= mdfp_pkg::ST_RUN;
               lockCnt_q <= 32'h0;
            end
            mdfp_pkg::ST_LOCK: begin
               if (tick) holdCnt_q <= holdCnt_q + 32'h1;
               if (holdCnt_q >= LOCK_TICKS) state_q <= mdfp_pkg::ST_RUN;
               lockCnt_q <= 32'h0;
            end
            default: state_q <= mdfp_pkg::ST_RUN;
         endcase
      end
   end

   // Thermal hysteresis: set above trip, clear only at release
   always_ff @(posedge clk or posedge rst) begin
      if (rst) thermal_q <= 1'b0;
      else if (thHiS) thermal_q <= 1'b1;
      else if (thLoS) thermal_q <= 1'b0;
   end

   // Direction from hall sequence; forward step order 101,100,110,010,011,001
   function automatic logic [2:0] nextFwd(input logic [2:0] h);
      case (h)
         3'b101: nextFwd = 3'b100;
         3'b100: nextFwd = 3'b110;
         3'b110: nextFwd = 3'b010;
         3'b010: nextFwd = 3'b011;
         3'b011: nextFwd = 3'b001;
         3'b001: nextFwd = 3'b101;
         default: nextFwd = 3'b000;
      endcase
   endfunction
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reverse_q <= 1'b0;
         illegal_q <= 1'b0;
      end else begin
         illegal_q <= !hallOk;
         // Decided on the first edge, well inside 60 degrees
         if (hall != hallPrev_q && hallOk && hallPrev_q != 3'b000 && hallPrev_q != 3'b111)
            reverse_q <= ((nextFwd(hallPrev_q) == hall) != dirFwd);
      end
   end

   // Block commutation table; reverse direction setting (dirFwd low) maps via complemented code
   function automatic logic [5:0] blockDrive(input logic [2:0] h);
      case (h)
         3'b101: blockDrive = 6'b011000;
         3'b100: blockDrive = 6'b010010;
         3'b110: blockDrive = 6'b000110;
         3'b010: blockDrive = 6'b100100;
         3'b011: blockDrive = 6'b100001;
         3'b001: blockDrive = 6'b001001;
         default: blockDrive = 6'b000000;
      endcase
   endfunction

   logic gatesOff;
   mdfp_pkg::mdfp_gate_s driveSel;
   assign gatesOff = softCut_q || thermal_q || !hallOk || state_q != mdfp_pkg::ST_RUN;
   always_comb begin
      if (reverse_q)
         driveSel = blockDrive(dirFwd ? hall : ~hall);
      else
         driveSel = sineSS_q;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gateOut <= 6'h00;
         faultOut <= 1'b0;
      end else begin
         gateOut <= gatesOff ? 6'h00 : driveSel;
         faultOut <= state_q != mdfp_pkg::ST_RUN || thermal_q || reverse_q
                     || illegal_q;
      end
   end

   // Read path
   logic [31:0] status;
   assign status = {24'h0, reverse_q, illegal_q, thermal_q, softCut_q, 2'b00, state_q};
   assign arready = !rvalid;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= mdfp_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rresp <= mdfp_pkg::RESP_OKAY;
         case (araddr)
            mdfp_pkg::REG_CTRL: rdata <= ctrl_q;
            mdfp_pkg::REG_STATUS: rdata <= status;
            mdfp_pkg::REG_TSCALE: rdata <= {24'h0, tscale_q};
            default: begin
               rdata <= 32'h0;
               rresp <= mdfp_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   a_illegal_off: assert property (@(posedge clk) disable iff (rst)
      !hallOk |=> gateOut == 6'h00) else $error("gates on with illegal hall");
   a_illegal_fault: assert property (@(posedge clk) disable iff (rst)
      !hallOk |=> ##1 faultOut) else $error("no fault on illegal hall");
   a_thermal_fault: assert property (@(posedge clk) disable iff (rst)
      thermal_q |=> faultOut && gateOut == 6'h00) else $error("thermal not shut");
   a_trip_enter: assert property (@(posedge clk) disable iff (rst)
      state_q == mdfp_pkg::ST_RUN && hardHit |=> state_q == mdfp_pkg::ST_TRIP)
      else $error("trip missed");
   a_trip_hold: assert property (@(posedge clk) disable iff (rst)
      state_q == mdfp_pkg::ST_TRIP |=> gateOut == 6'h00 && faultOut)
      else $error("trip not holding");
   a_lock_hold: assert property (@(posedge clk) disable iff (rst)
      state_q == mdfp_pkg::ST_LOCK |=> gateOut == 6'h00 && faultOut)
      else $error("lock not holding");
   a_soft_clear: assert property (@(posedge clk) disable iff (rst)
      softCut_q && pwmS && !softS |=> !softCut_q) else $error("soft cut kept");
   a_fault_low: assert property (@(posedge clk) disable iff (rst)
      state_q == mdfp_pkg::ST_RUN && !thermal_q && !reverse_q && !illegal_q
      |=> !faultOut) else $error("spurious fault");
   a_soft_cut: assert property (@(posedge clk) disable iff (rst)
      softCut_q |=> gateOut == 6'h00) else $error("soft cut ignored");

   // Entry steps: state moves first, outputs follow one flop later
   sequence s_trip_entry;
      state_q == mdfp_pkg::ST_RUN && hardHit;
   endsequence
   sequence s_lock_entry;
      state_q == mdfp_pkg::ST_RUN && !hardHit && lockEn && lockCnt_q >= DETECT_TICKS;
   endsequence
   sequence s_all_off;
      gateOut == 6'h00 && faultOut;
   endsequence
   a_trip_shut: assert property (@(posedge clk) disable iff (rst)
      s_trip_entry |-> ##2 s_all_off) else $error("trip not shut");
   a_lock_enter: assert property (@(posedge clk) disable iff (rst)
      s_lock_entry |=> state_q == mdfp_pkg::ST_LOCK ##1 s_all_off) else $error("lock missed");
endmodule
`default_nettype wire

// [test/mdfp_mcu_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mdfp_mcu_model #(
   parameter int RESTART_CYC = 100
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Fault line and motor control
   input wire logic faultOut,
   output logic stopMotor
);
   int wait_q;
   // Restart span is shortened so the run stays brief
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_q <= 0;
      end else if (faultOut) begin
         wait_q <= RESTART_CYC;
      end else if (wait_q > 0) begin
         wait_q <= wait_q - 1;
      end
   end
   assign stopMotor = faultOut || (wait_q > 0);
endmodule
`default_nettype wire

// [test/motor_driver_fault_protection_test.sv]
`timescale 1ns/1ps
`default_nettype none
module motor_driver_fault_protection_test;
   logic clk, rst, hallU, hallV, hallW, softLimitCmp, hardTripCmp, thermHighCmp, thermLowCmp;
   logic pwmPeriodStart, awvalid, wvalid, bready, arvalid, rready, stopMotor;
   logic awready, wready, bvalid, arready, rvalid, faultOut;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [5:0] sineGates, gateOut;
   logic [2:0] seqTab [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
   int bad_count, samples_checked, pos;
   mdfp_top #(.HOLD_TICKS(20), .DETECT_TICKS(50), .LOCK_TICKS(80), .TICK_CYCLES(2)) dut_u (
      .clk(clk), .rst(rst), .hallU(hallU), .hallV(hallV), .hallW(hallW),
      .softLimitCmp(softLimitCmp), .hardTripCmp(hardTripCmp), .thermHighCmp(thermHighCmp),
      .thermLowCmp(thermLowCmp), .pwmPeriodStart(pwmPeriodStart), .sineGates(sineGates),
      .gateOut(gateOut), .faultOut(faultOut), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   mdfp_mcu_model mcu_u (.clk(clk), .rst(rst), .faultOut(faultOut), .stopMotor(stopMotor));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #400000;
      bad_count++;
      test_done();
   end
   function automatic logic [5:0] fwdGate(input logic [2:0] h);
      case (h)
         3'h5: fwdGate = 6'h18;
         3'h4: fwdGate = 6'h12;
         3'h6: fwdGate = 6'h06;
         3'h2: fwdGate = 6'h24;
         3'h3: fwdGate = 6'h21;
         3'h1: fwdGate = 6'h09;
         default: fwdGate = 6'h00;
      endcase
   endfunction
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task test_done;
      if (bad_count == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task waitRun;
      for (int n = 0; n < 500 && stopMotor !== 1'b0; n++) @(posedge clk);
   endtask
   // Ready is sampled mid-cycle, so the result never races the edge that takes it
   task axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w, done, tA, tW;
      logic [1:0] r;
      aw = 1'b0;
      w = 1'b0;
      done = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(negedge clk);
         tA = awready && !aw;
         tW = wready && !w;
         done = aw && w && bvalid;
         r = bresp;
         @(posedge clk);
         if (tA) begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (tW) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b0;
      check(r, er);
   endtask
   task axiRead(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic tk, taken, done;
      logic [31:0] d;
      logic [1:0] r;
      taken = 1'b0;
      done = 1'b0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(negedge clk);
         tk = arready && !taken;
         done = taken && rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (tk) begin
            taken = 1'b1;
            arvalid <= 1'b0;
         end
      end
      rready <= 1'b0;
      check(d, ed);
      check(r, er);
   endtask
   task setHall(input logic [2:0] h, input logic [5:0] sg);
      @(posedge clk);
      {hallU, hallV, hallW} <= h;
      sineGates <= sg;
      cyc(6);
   endtask
   task rotate(input logic rotFwd, input logic dirSel, input int steps);
      logic [5:0] sg, exp;
      for (int k = 0; k < steps; k++) begin
         sg = 6'($urandom);
         pos = rotFwd ? (pos + 1) % 6 : (pos + 5) % 6;
         setHall(seqTab[pos], sg);
         exp = (rotFwd == dirSel) ? sg : fwdGate(dirSel ? seqTab[pos] : ~seqTab[pos]);
         if (k > 0) begin
            check(gateOut, exp);
            check(faultOut, rotFwd != dirSel);
         end
      end
   endtask
   task gateFault(input logic [5:0] g, input logic f);
      check(gateOut, g);
      check(faultOut, f);
   endtask
   initial begin
      void'($urandom(32'h859c0604));
      {rst, softLimitCmp, hardTripCmp, thermHighCmp, pwmPeriodStart} = 5'h1f;
      {softLimitCmp, hardTripCmp, thermHighCmp, pwmPeriodStart, thermLowCmp} = 5'h01;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata, wstrb, sineGates} = '0;
      pos = 0;
      {hallU, hallV, hallW} = seqTab[0];
      cyc(20);
      gateFault(6'h00, 1'b0);
      rst <= 1'b0;
      axiRead(mdfp_pkg::REG_CTRL, mdfp_pkg::CTRL_RESET, mdfp_pkg::RESP_OKAY);
      axiWrite(mdfp_pkg::REG_TSCALE, 32'h0, mdfp_pkg::RESP_OKAY);
      axiRead(mdfp_pkg::REG_TSCALE, 32'(mdfp_pkg::TSCALE_RESET), mdfp_pkg::RESP_OKAY);
      axiWrite(8'h0c, 32'h5, mdfp_pkg::RESP_SLVERR);
      axiRead(8'h0c, 32'h0, mdfp_pkg::RESP_SLVERR);
      axiWrite(mdfp_pkg::REG_STATUS, 32'hff, mdfp_pkg::RESP_OKAY);
      axiRead(mdfp_pkg::REG_STATUS, 32'h0, mdfp_pkg::RESP_OKAY);
      axiWrite(mdfp_pkg::REG_CTRL, 32'h1, mdfp_pkg::RESP_OKAY);
      rotate(1'b1, 1'b1, 8);
      rotate(1'b0, 1'b1, 7);
      axiWrite(mdfp_pkg::REG_CTRL, 32'h0, mdfp_pkg::RESP_OKAY);
      rotate(1'b0, 1'b0, 4);
      rotate(1'b1, 1'b0, 7);
      axiWrite(mdfp_pkg::REG_CTRL, 32'h1, mdfp_pkg::RESP_OKAY);
      rotate(1'b1, 1'b1, 3);
      for (int i = 0; i < 2; i++) begin
         setHall(i ? 3'h7 : 3'h0, 6'h3f);
         gateFault(6'h00, 1'b1);
      end
      setHall(seqTab[pos], 6'h00);
      rotate(1'b1, 1'b1, 3);
      waitRun();
      // Soft cut: no fault, held until the next carrier start
      softLimitCmp <= 1'b1;
      sineGates <= 6'h2a;
      cyc(150);
      gateFault(6'h2a, 1'b0);
      cyc(60);
      gateFault(6'h00, 1'b0);
      softLimitCmp <= 1'b0;
      cyc(10);
      gateFault(6'h00, 1'b0);
      pwmPeriodStart <= 1'b1;
      cyc(1);
      pwmPeriodStart <= 1'b0;
      cyc(6);
      gateFault(6'h2a, 1'b0);
      hardTripCmp <= 1'b1;
      cyc(100);
      hardTripCmp <= 1'b0;
      cyc(10);
      gateFault(6'h2a, 1'b0);
      hardTripCmp <= 1'b1;
      cyc(140);
      hardTripCmp <= 1'b0;
      gateFault(6'h00, 1'b1);
      axiRead(mdfp_pkg::REG_STATUS, 32'h01, mdfp_pkg::RESP_OKAY);
      cyc(15);
      gateFault(6'h00, 1'b1);
      cyc(60);
      gateFault(6'h2a, 1'b0);
      waitRun();
      thermLowCmp <= 1'b0;
      thermHighCmp <= 1'b1;
      cyc(6);
      gateFault(6'h00, 1'b1);
      thermHighCmp <= 1'b0;
      cyc(6);
      gateFault(6'h00, 1'b1);
      axiRead(mdfp_pkg::REG_STATUS, 32'h20, mdfp_pkg::RESP_OKAY);
      thermLowCmp <= 1'b1;
      cyc(6);
      gateFault(6'h2a, 1'b0);
      waitRun();
      axiWrite(mdfp_pkg::REG_CTRL, 32'h3, mdfp_pkg::RESP_OKAY);
      rotate(1'b1, 1'b1, 1);
      cyc(120);
      gateFault(6'h00, 1'b1);
      axiRead(mdfp_pkg::REG_STATUS, 32'h02, mdfp_pkg::RESP_OKAY);
      cyc(80);
      gateFault(6'h00, 1'b1);
      cyc(70);
      gateFault(sineGates, 1'b0);
      rotate(1'b1, 1'b1, 3);
      test_done();
   end
endmodule
`default_nettype wire
